// File: test/card_side_model.sv
`timescale 1ns/1ps
`default_nettype none
module card_side_model (
  input wire logic ref_clk,
  input wire logic converter_enable,
  input wire logic card_clk_out,
  input wire logic card_rst_out,
  input wire logic card_io_oe,
  input wire logic card_pull,
  input wire logic sag,
  input wire logic rst_short,
  input wire logic clk_short,
  output logic supply_at_target,
  output logic supply_below_level,
  output logic card_clk_sense,
  output logic card_rst_sense,
  output logic card_io_in
);
  int ramp_r = 0;
  // soft start longer than the mismatch window
  always_ff @(posedge ref_clk) ramp_r <= converter_enable ? ramp_r + 1 : 0;
  assign supply_at_target = converter_enable && ramp_r > 400 && !sag;
  assign supply_below_level = sag;
  assign card_clk_sense = card_clk_out && !clk_short;
  assign card_rst_sense = card_rst_out && !rst_short;
  // pulled up contact, low if either side pulls
  assign card_io_in = !(card_io_oe || card_pull);
endmodule : card_side_model
`default_nettype wire

// File: test/smart_card_interface_control_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "smart_card_map.svh"
module smart_card_props #(
  parameter int DEBOUNCE_CYCLES = `PRESENCE_SWITCH_IN_DEBOUNCE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic io_clk,
  input wire logic power_request_n,
  input wire logic host_clock_in,
  input wire logic host_reset_in,
  input wire logic presence_switch_in,
  input wire logic supply_below_level,
  input wire logic host_data_oe,
  input wire logic card_io_oe,
  input wire logic converter_enable,
  input wire logic converter_select_5v,
  input wire logic supply_discharge,
  input wire logic supply_ready_n,
  input wire logic card_present_n,
  input wire logic card_clk_out,
  input wire logic card_rst_out,
  input wire logic alarm_active
);
  logic [9:0] below_cnt_r;
  logic [31:0] presence_switch_in_cnt_r;
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) below_cnt_r <= '0;
    else below_cnt_r <= (supply_below_level && converter_enable) ? below_cnt_r + 10'h001 : '0;
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) presence_switch_in_cnt_r <= '0;
    else presence_switch_in_cnt_r <= presence_switch_in ? presence_switch_in_cnt_r + 32'h1 : '0;
  a_clk_gated: assert property (@(posedge ref_clk) disable iff (!reset_n)
    supply_ready_n && $past(supply_ready_n) |-> !card_clk_out) else $error("card clock early");
  a_rst_gated: assert property (@(posedge ref_clk) disable iff (!reset_n)
    supply_ready_n && $past(supply_ready_n) |-> !card_rst_out) else $error("card reset early");
  a_select_held: assert property (@(posedge ref_clk) disable iff (!reset_n)
    converter_enable && $past(converter_enable) |-> $stable(converter_select_5v))
    else $error("select changed");
  a_discharge_state: assert property (@(posedge ref_clk) disable iff (!reset_n)
    power_request_n[*4] |-> supply_discharge && !converter_enable) else $error("discharge wrong");
  a_ready_drop: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(converter_enable) |-> ##[0:1] supply_ready_n) else $error("ready stuck low");
  a_alarm_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!power_request_n)[*4] ##0 alarm_active |=> alarm_active) else $error("alarm left");
  a_below_bound: assert property (@(posedge ref_clk) disable iff (!reset_n)
    below_cnt_r < 10'h1FE) else $error("no alarm on low supply");
  a_debounce_min: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $fell(card_present_n) |-> presence_switch_in_cnt_r >= DEBOUNCE_CYCLES) else $error("card too soon");
  a_fast_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!presence_switch_in)[*5] |-> card_present_n) else $error("card not released");
  a_copy_host: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!supply_ready_n && converter_enable)[*6]
    |-> {card_clk_out, card_rst_out} == $past({host_clock_in, host_reset_in}, 3))
    else $error("card pins not following host");
  a_one_way: assert property (@(posedge io_clk) disable iff (!reset_n)
    !(card_io_oe && host_data_oe)) else $error("both sides driven");
  a_idle_io_low: assert property (@(posedge io_clk) disable iff (!reset_n)
    (!converter_enable)[*5] |-> card_io_oe) else $error("card io not low");
  a_host_wait: assert property (@(posedge io_clk) disable iff (!reset_n)
    supply_ready_n[*5] |-> !host_data_oe) else $error("data early");
endmodule : smart_card_props
`default_nettype wire

// File: test/test_smart_card_interface_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_smart_card_interface_control;
  localparam int DEB = 20;
  logic ref_clk = 1'b0;
  logic io_clk = 1'b0;
  logic reset_n = 1'b0;
  logic power_request_n = 1'b1;
  logic supply_voltage_select = 1'b0;
  logic host_clock_in = 1'b0;
  logic host_reset_in = 1'b0;
  logic presence_switch_in = 1'b0;
  logic host_pull = 1'b0;
  logic card_pull = 1'b0;
  logic sag = 1'b0;
  logic rst_short = 1'b0;
  logic clk_short = 1'b0;
  logic host_data_in, host_data_out, host_data_oe, card_io_in, card_io_out, card_io_oe;
  logic converter_enable, converter_select_5v, supply_discharge, supply_ready_n;
  logic card_present_n, card_clk_out, card_rst_out, alarm_active;
  logic supply_at_target, supply_below_level, card_clk_sense, card_rst_sense;
  int n_errors = 0;
  int samples_checked = 0;
  int i;
  initial forever #5 ref_clk = ~ref_clk;
  initial
  begin
    #3;
    forever #6 io_clk = ~io_clk;
  end
  assign host_data_in = !(host_data_oe || host_pull);
  smart_card_interface_control #(.DEBOUNCE_CYCLES(DEB)) dut_u (.*);
  card_side_model card_u (.*);
  task automatic check(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : check
  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic bound(input int n);
    check("wait_bound", 1'b1, n < 700);
    if (n >= 700) complete_run();
  endtask : bound
  task automatic t_power_up(input logic sel);
    supply_voltage_select = sel;
    cyc(1);
    power_request_n = 1'b0;
    host_reset_in = 1'b1;
    host_clock_in = 1'b1;
    cyc(6);
    check("converter_enable", 1'b1, converter_enable);
    supply_voltage_select = !sel;
    cyc(6);
    check("converter_select_5v", sel, converter_select_5v);
    check("card_clk_out", 1'b0, card_clk_out);
    for (i = 0; i < 700 && supply_ready_n !== 1'b0; i++) cyc(1);
    bound(i);
    cyc(6);
    check("card_rst_out", 1'b1, card_rst_out);
    check("card_clk_out", 1'b1, card_clk_out);
  endtask : t_power_up
  task automatic t_power_down;
    power_request_n = 1'b1;
    host_reset_in = 1'b0;
    host_clock_in = 1'b0;
    cyc(10);
    check("alarm_active", 1'b0, alarm_active);
    check("supply_discharge", 1'b1, supply_discharge);
  endtask : t_power_down
  task automatic t_link;
    check("host_data_out", 1'b0, host_data_out);
    check("card_io_out", 1'b0, card_io_out);
    host_pull = 1'b1;
    cyc(8);
    check("card_io_in", 1'b0, card_io_in);
    card_pull = 1'b1;
    host_pull = 1'b0;
    cyc(8);
    check("host_data_in", 1'b1, host_data_in);
    card_pull = 1'b0;
    cyc(8);
    check("card_io_in", 1'b1, card_io_in);
    card_pull = 1'b1;
    cyc(8);
    check("host_data_in", 1'b0, host_data_in);
    card_pull = 1'b0;
    cyc(8);
    check("host_data_in", 1'b1, host_data_in);
  endtask : t_link
  task automatic t_supply_fault;
    sag = 1'b1;
    for (i = 0; i < 700 && alarm_active !== 1'b1; i++) cyc(1);
    bound(i);
    check("supply_ready_n", 1'b1, supply_ready_n);
    sag = 1'b0;
    cyc(20);
    check("alarm_active", 1'b1, alarm_active);
    t_power_down();
  endtask : t_supply_fault
  task automatic t_presence;
    presence_switch_in = 1'b1;
    cyc(DEB - 4);
    check("card_present_n", 1'b1, card_present_n);
    cyc(10);
    check("card_present_n", 1'b0, card_present_n);
    t_power_up(1'b0);
    presence_switch_in = 1'b0;
    cyc(5);
    check("card_present_n", 1'b1, card_present_n);
    check("alarm_active", 1'b1, alarm_active);
    check("card_rst_out", 1'b0, card_rst_out);
    t_power_down();
  endtask : t_presence
  task automatic t_rst_short;
    t_power_up(1'b1);
    rst_short = 1'b1;
    for (i = 0; i < 700 && alarm_active !== 1'b1; i++) cyc(1);
    bound(i);
    rst_short = 1'b0;
    t_power_down();
    t_power_up(1'b0);
    clk_short = 1'b1;
    for (i = 0; i < 700 && alarm_active !== 1'b1; i++) cyc(1);
    bound(i);
    clk_short = 1'b0;
    t_power_down();
  endtask : t_rst_short
  initial
  begin
    cyc(12);
    reset_n = 1'b1;
    cyc(4);
    check("card_io_in", 1'b0, card_io_in);
    t_power_up(1'b1);
    t_link();
    t_supply_fault();
    t_presence();
    t_rst_short();
    complete_run();
  end
endmodule : test_smart_card_interface_control
bind smart_card_interface_control smart_card_props #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) props_u (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .io_clk(io_clk),
  .power_request_n(power_request_n),
  .host_clock_in(host_clock_in),
  .host_reset_in(host_reset_in),
  .presence_switch_in(presence_switch_in),
  .supply_below_level(supply_below_level),
  .host_data_oe(host_data_oe),
  .card_io_oe(card_io_oe),
  .converter_enable(converter_enable),
  .converter_select_5v(converter_select_5v),
  .supply_discharge(supply_discharge),
  .supply_ready_n(supply_ready_n),
  .card_present_n(card_present_n),
  .card_clk_out(card_clk_out),
  .card_rst_out(card_rst_out),
  .alarm_active(alarm_active)
);
`default_nettype wire

// File: verilog/smart_card_interface_control.sv
// What this block does
// - power request low enters Active, starts converter
// - supply-ok low once supply reaches target
// - card reset and clock wait for supply-ok
// - card I/O channel waits for supply-ok
// - voltage select latched on request fall only
// - supply below level 5 us gives Alarm
// - Idle and Alarm discharge card supply
// - Idle drives card I/O low
// - both data sides high means resting
// - first low side is input, no backflow
// - input release returns channel to rest
// - late output-side low never flows back
// - direction chosen only from both-high rest
// - card reset low until supply-ok
// - reset pin mismatch several microseconds gives Alarm
// - mismatch check only after supply-ok
// - card clock low until supply-ok
// - presence debounced 40 ms before card reported
// - Alarm held until power request high
// - supply-ok returns high on Alarm
// - card-present low after debounce, fast release
// - Active with supply-ok copies host clock and reset out
`timescale 1ns/1ps
`default_nettype none

`include "smart_card_map.svh"

module smart_card_interface_control #(
  parameter int DEBOUNCE_CYCLES = `PRESENCE_SWITCH_IN_DEBOUNCE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic io_clk,
  input wire logic power_request_n,
  input wire logic supply_voltage_select,
  input wire logic host_clock_in,
  input wire logic host_reset_in,
  input wire logic presence_switch_in,
  input wire logic supply_at_target,
  input wire logic supply_below_level,
  input wire logic card_clk_sense,
  input wire logic card_rst_sense,
  input wire logic host_data_in,
  output logic host_data_out,
  output logic host_data_oe,
  input wire logic card_io_in,
  output logic card_io_out,
  output logic card_io_oe,
  output logic converter_enable,
  output logic converter_select_5v,
  output logic supply_discharge,
  output logic supply_ready_n,
  output logic card_present_n,
  output logic card_clk_out,
  output logic card_rst_out,
  output logic alarm_active
);

  localparam int LOW_CYC = `SUPPLY_LOW_CYCLES;
  localparam int MIS_CYC = `MISMATCH_CYCLES;
  localparam int LOW_W = $clog2(LOW_CYC + 1);
  localparam int MIS_W = $clog2(MIS_CYC + 1);
  localparam int DB_W = $clog2(DEBOUNCE_CYCLES + 1);

  // reference domain input synchronisation
  logic [8:0] ref_sync;
  logic pwr_req_n_s;
  logic vsel_s;
  logic host_clk_s;
  logic host_rst_s;
  logic presence_s;
  logic at_target_s;
  logic below_level_s;
  logic clk_sense_s;
  logic rst_sense_s;

  sync_two #(
    .WIDTH(9),
    .INIT(`REF_SYNC_INIT)
  ) u_ref_sync (
    .clk(ref_clk),
    .reset_n(reset_n),
    .d({power_request_n, supply_voltage_select, host_clock_in,
        host_reset_in, presence_switch_in, supply_at_target,
        supply_below_level, card_clk_sense, card_rst_sense}),
    .q(ref_sync)
  );

  assign pwr_req_n_s = ref_sync[8];
  assign vsel_s = ref_sync[7];
  assign host_clk_s = ref_sync[6];
  assign host_rst_s = ref_sync[5];
  assign presence_s = ref_sync[4];
  assign at_target_s = ref_sync[3];
  assign below_level_s = ref_sync[2];
  assign clk_sense_s = ref_sync[1];
  assign rst_sense_s = ref_sync[0];

  smart_card_pkg::power_state_e state_r;
  smart_card_pkg::power_state_e state_nxt;
  logic ready_r;
  logic vsel_r;
  logic card_present_r;
  logic [DB_W-1:0] db_cnt_r;
  logic [LOW_W-1:0] low_cnt_r;
  logic [MIS_W-1:0] rst_mis_cnt_r;
  logic [MIS_W-1:0] clk_mis_cnt_r;
  logic card_clk_r;
  logic card_rst_r;
  logic supply_fault;
  logic rst_fault;
  logic clk_fault;
  logic removal_fault;
  logic any_fault;

  // presence debounce and card-present report
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      db_cnt_r <= '0;
      card_present_r <= 1'b0;
    end
    else if (!presence_s)
    begin
      db_cnt_r <= '0;
      card_present_r <= 1'b0;
    end
    else if (db_cnt_r == DB_W'(DEBOUNCE_CYCLES - 1))
    begin
      card_present_r <= 1'b1;
    end
    else
    begin
      db_cnt_r <= db_cnt_r + 1'b1;
    end
  end

  // supply below level timer
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      low_cnt_r <= '0;
    end
    else if (state_r != smart_card_pkg::PWR_ACTIVE || !below_level_s)
    begin
      low_cnt_r <= '0;
    end
    else if (low_cnt_r != LOW_W'(LOW_CYC))
    begin
      low_cnt_r <= low_cnt_r + 1'b1;
    end
  end

  // card reset pin against host reset input
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_mis_cnt_r <= '0;
    end
    else if (!ready_r || state_r != smart_card_pkg::PWR_ACTIVE
             || rst_sense_s == host_rst_s)
    begin
      rst_mis_cnt_r <= '0;
    end
    else if (rst_mis_cnt_r != MIS_W'(MIS_CYC))
    begin
      rst_mis_cnt_r <= rst_mis_cnt_r + 1'b1;
    end
  end

  // card clock pin against host clock input
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clk_mis_cnt_r <= '0;
    end
    else if (!ready_r || state_r != smart_card_pkg::PWR_ACTIVE
             || clk_sense_s == host_clk_s)
    begin
      clk_mis_cnt_r <= '0;
    end
    else if (clk_mis_cnt_r != MIS_W'(MIS_CYC))
    begin
      clk_mis_cnt_r <= clk_mis_cnt_r + 1'b1;
    end
  end

  assign supply_fault = low_cnt_r == LOW_W'(LOW_CYC);
  assign rst_fault = rst_mis_cnt_r == MIS_W'(MIS_CYC);
  assign clk_fault = clk_mis_cnt_r == MIS_W'(MIS_CYC);
  assign removal_fault = card_present_r && !presence_s;
  assign any_fault = supply_fault || rst_fault || clk_fault || removal_fault;

  // power sequencing
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      smart_card_pkg::PWR_IDLE:
      begin
        if (!pwr_req_n_s)
        begin
          state_nxt = smart_card_pkg::PWR_ACTIVE;
        end
      end
      smart_card_pkg::PWR_ACTIVE:
      begin
        if (pwr_req_n_s)
        begin
          state_nxt = smart_card_pkg::PWR_IDLE;
        end
        else if (any_fault)
        begin
          state_nxt = smart_card_pkg::PWR_ALARM;
        end
      end
      smart_card_pkg::PWR_ALARM:
      begin
        if (pwr_req_n_s)
        begin
          state_nxt = smart_card_pkg::PWR_IDLE;
        end
      end
      default:
      begin
        state_nxt = smart_card_pkg::PWR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_r <= smart_card_pkg::PWR_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // voltage select latch on the request falling edge
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      vsel_r <= 1'b0;
    end
    else if (state_r == smart_card_pkg::PWR_IDLE && !pwr_req_n_s)
    begin
      vsel_r <= vsel_s;
    end
  end

  // supply-ok flag
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ready_r <= 1'b0;
    end
    else if (state_nxt != smart_card_pkg::PWR_ACTIVE)
    begin
      ready_r <= 1'b0;
    end
    else if (at_target_s)
    begin
      ready_r <= 1'b1;
    end
  end

  // card clock and reset channels
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      card_clk_r <= 1'b0;
      card_rst_r <= 1'b0;
    end
    else if (ready_r && state_r == smart_card_pkg::PWR_ACTIVE)
    begin
      card_clk_r <= host_clk_s;
      card_rst_r <= host_rst_s;
    end
    else
    begin
      card_clk_r <= 1'b0;
      card_rst_r <= 1'b0;
    end
  end

  assign converter_enable = state_r == smart_card_pkg::PWR_ACTIVE;
  assign supply_discharge = state_r != smart_card_pkg::PWR_ACTIVE;
  assign converter_select_5v = vsel_r;
  assign supply_ready_n = !ready_r;
  assign card_present_n = !card_present_r;
  assign card_clk_out = card_clk_r;
  assign card_rst_out = card_rst_r;
  assign alarm_active = state_r == smart_card_pkg::PWR_ALARM;

  // link domain: data channel direction arbiter
  logic [3:0] link_sync;
  logic host_data_s;
  logic card_io_s;
  logic link_en_s;
  logic link_ground_s;
  logic link_en_src;
  logic link_ground_src;

  assign link_en_src = ready_r;
  assign link_ground_src = state_r != smart_card_pkg::PWR_ACTIVE;

  sync_two #(
    .WIDTH(4),
    .INIT(`LINK_SYNC_INIT)
  ) u_link_sync (
    .clk(io_clk),
    .reset_n(reset_n),
    .d({host_data_in, card_io_in, link_en_src, link_ground_src}),
    .q(link_sync)
  );

  assign host_data_s = link_sync[3];
  assign card_io_s = link_sync[2];
  assign link_en_s = link_sync[1];
  assign link_ground_s = link_sync[0];

  smart_card_pkg::link_dir_e dir_r;
  smart_card_pkg::link_dir_e dir_nxt;
  logic host_data_oe_r;
  logic card_io_oe_r;

  always_comb
  begin
    dir_nxt = dir_r;
    if (!link_en_s)
    begin
      dir_nxt = smart_card_pkg::DIR_REST;
    end
    else
    begin
      case (dir_r)
        smart_card_pkg::DIR_REST:
        begin
          if (!host_data_s)
          begin
            dir_nxt = smart_card_pkg::DIR_HOST_TO_CARD;
          end
          else if (!card_io_s)
          begin
            dir_nxt = smart_card_pkg::DIR_CARD_TO_HOST;
          end
        end
        smart_card_pkg::DIR_HOST_TO_CARD:
        begin
          if (host_data_s)
          begin
            dir_nxt = smart_card_pkg::DIR_SETTLE;
          end
        end
        smart_card_pkg::DIR_CARD_TO_HOST:
        begin
          if (card_io_s)
          begin
            dir_nxt = smart_card_pkg::DIR_SETTLE;
          end
        end
        smart_card_pkg::DIR_SETTLE:
        begin
          if (host_data_s && card_io_s)
          begin
            dir_nxt = smart_card_pkg::DIR_REST;
          end
        end
        default:
        begin
          dir_nxt = smart_card_pkg::DIR_REST;
        end
      endcase
    end
  end

  always_ff @(posedge io_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dir_r <= smart_card_pkg::DIR_REST;
    end
    else
    begin
      dir_r <= dir_nxt;
    end
  end

  // open-drain drivers: the output side is pulled low, and card I/O also whenever not Active
  always_ff @(posedge io_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      host_data_oe_r <= 1'b0;
      card_io_oe_r <= 1'b1;
    end
    else
    begin
      host_data_oe_r <= dir_nxt == smart_card_pkg::DIR_CARD_TO_HOST;
      card_io_oe_r <= link_ground_s
                      || dir_nxt == smart_card_pkg::DIR_HOST_TO_CARD;
    end
  end

  assign host_data_out = 1'b0;
  assign host_data_oe = host_data_oe_r;
  assign card_io_out = 1'b0;
  assign card_io_oe = card_io_oe_r;

endmodule : smart_card_interface_control

`default_nettype wire

// File: verilog/smart_card_map.svh
`ifndef SMART_CARD_MAP_SVH
`define SMART_CARD_MAP_SVH

// reference clock period
`define REF_CLK_PERIOD_NS 10

// card supply below level for this long raises the alarm
`define SUPPLY_LOW_NS 5000
`define SUPPLY_LOW_CYCLES \
  ((`SUPPLY_LOW_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

// card clock or reset pin disagreeing with the host input for this long
`define MISMATCH_NS 3000
`define MISMATCH_CYCLES \
  ((`MISMATCH_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

// presence switch debounce, least time
`define PRESENCE_SWITCH_IN_DEBOUNCE_MS 40
`define PRESENCE_SWITCH_IN_DEBOUNCE_CYCLES \
  ((`PRESENCE_SWITCH_IN_DEBOUNCE_MS * 1000000 + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

// synchroniser reset levels
`define REF_SYNC_INIT 9'h100
`define LINK_SYNC_INIT 4'hD

`endif

// File: verilog/smart_card_pkg.sv
package smart_card_pkg;

  typedef enum logic [2:0] {
    PWR_IDLE   = 3'b001,
    PWR_ACTIVE = 3'b010,
    PWR_ALARM  = 3'b100
  } power_state_e;

  typedef enum logic [3:0] {
    DIR_REST         = 4'b0001,
    DIR_HOST_TO_CARD = 4'b0010,
    DIR_CARD_TO_HOST = 4'b0100,
    DIR_SETTLE       = 4'b1000
  } link_dir_e;

endpackage : smart_card_pkg

// File: verilog/sync_two.sv
`timescale 1ns/1ps
`default_nettype none

// two flip-flop level synchroniser, one lane per bit
module sync_two #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= INIT;
      q <= INIT;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : sync_two

`default_nettype wire
